//--- verilog/timer_flag_regs.svh
// Register offsets, field positions and reset values of the timer flag block
`ifndef TIMER_FLAG_REGS_SVH
`define TIMER_FLAG_REGS_SVH

`define TFE_ADDR_CTRL 4'h0
`define TFE_ADDR_MOD 4'h1
`define TFE_ADDR_CNT 4'h2
`define TFE_ADDR_STATUS 4'h3
`define TFE_ADDR_MASK 4'h4
`define TFE_ADDR_CH0CTRL 4'h5
`define TFE_ADDR_CH1CTRL 4'h6
`define TFE_ADDR_CH0VAL 4'h7
`define TFE_ADDR_CH1VAL 4'h8

`define TFE_CTRL_RUN 0
`define TFE_CTRL_CENTER 1
`define TFE_CTRL_PRE_LO 2
`define TFE_CTRL_PRE_HI 5
`define TFE_CHC_MODE_LO 0
`define TFE_CHC_MODE_HI 1
`define TFE_CHC_EDGE_LO 2
`define TFE_CHC_EDGE_HI 3

`define TFE_STAT_WRAP 0
`define TFE_STAT_CH0 1

`define TFE_CTRL_RESET 16'h0000
`define TFE_MOD_RESET 16'h0000
`define TFE_CNT_RESET 16'h0000
`define TFE_CNT_TOP 16'hffff
`define TFE_ZERO16 16'h0000

`endif

//--- verilog/timer_flag_pkg.sv
// Types shared by the timer flag block
package timer_flag_pkg;
  typedef enum logic [1:0] {
    CH_CAPTURE = 2'b00,
    CH_COMPARE = 2'b01,
    CH_PWM = 2'b10,
    CH_OFF = 2'b11
  } ch_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY = 2'b11
  } edge_sel_t;

  typedef enum logic [0:0] {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;
endpackage : timer_flag_pkg

//--- verilog/flag_clear_cell.sv
// One event flag with read-then-write-zero clearing
`timescale 1ns/10ps
module flag_clear_cell (
  input wire logic clk,
  input wire logic resetn,
  input wire logic setEvent,
  input wire logic readSeen,
  input wire logic writeZero,
  output logic flag
);
  logic flag_reg;
  logic flag_next;
  logic armed_reg;
  logic armed_next;

  // Arm on a read of the set flag; any new event disarms so it stays set
  always_comb begin
    flag_next = flag_reg;
    armed_next = armed_reg;
    if (setEvent) begin
      flag_next = 1'b1;
      armed_next = 1'b0;
    end else if (writeZero && armed_reg) begin
      flag_next = 1'b0;
      armed_next = 1'b0;
    end else if (readSeen && flag_reg) begin
      armed_next = 1'b1;
    end
  end

  // Flag state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      armed_reg <= armed_next;
    end
  end

  assign flag = flag_reg;

  a_clear_needs_read: assert property (@(posedge clk)
    disable iff (!resetn)
    $fell(flag_reg) |-> $past(armed_reg) && $past(writeZero)
    && !$past(setEvent))
    else $error("Flag cleared without a prior read");
  a_event_keeps_set: assert property (@(posedge clk)
    disable iff (!resetn)
    setEvent |=> flag_reg)
    else $error("Event did not set flag");
endmodule : flag_clear_cell

//--- verilog/timer_flag_event_logic.sv
// Timer counter with wrap and channel event flags and interrupt
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "timer_flag_regs.svh"
module timer_flag_event_logic #(
  parameter int NCH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [NCH-1:0] chIn,
  output logic [NCH-1:0] chOut,
  output logic irq
);
  import timer_flag_pkg::*;

  localparam int NF = NCH + 1;

  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] mod_reg, mod_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [NF-1:0] mask_reg, mask_next;
  logic [3:0] chCtrl_reg [NCH];
  logic [15:0] chVal_reg [NCH];
  logic [3:0] pre_reg, pre_next;
  count_dir_t dir_reg, dir_next;
  logic [15:0] rdata_reg, rdata_next;
  logic irq_reg;
  logic [NCH-1:0] out_reg;
  logic [NCH-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [NF-1:0] flags;
  logic [NF-1:0] setEv;
  logic tick;
  logic wrapEv;
  logic running;
  logic center;
  logic [15:0] top;
  logic statRead;
  logic statWrite;

  assign running = ctrl_reg[`TFE_CTRL_RUN];
  assign center = ctrl_reg[`TFE_CTRL_CENTER];
  assign top = (mod_reg == `TFE_ZERO16) ? `TFE_CNT_TOP : mod_reg;
  assign statRead = rd && (addr == `TFE_ADDR_STATUS);
  assign statWrite = wr && (addr == `TFE_ADDR_STATUS);

  // Prescaler: counting clock enable every 2^pre cycles, every 16 cycles for pre 4 and above
  always_comb begin
    pre_next = pre_reg + 4'h1;
    tick = 1'b0;
    case (ctrl_reg[`TFE_CTRL_PRE_HI:`TFE_CTRL_PRE_LO])
      4'h0: tick = 1'b1;
      4'h1: tick = pre_reg[0];
      4'h2: tick = &pre_reg[1:0];
      4'h3: tick = &pre_reg[2:0];
      default: tick = &pre_reg;
    endcase
    tick = tick && running;
    if (!running) begin
      pre_next = 4'h0;
    end
  end

  // Counter and direction with wrap event
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    wrapEv = 1'b0;
    if (tick) begin
      if (!center) begin
        dir_next = DIR_UP;
        if (cnt_reg == top) begin
          cnt_next = `TFE_CNT_RESET;
          wrapEv = 1'b1;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end else if (dir_reg == DIR_UP) begin
        if (cnt_reg >= mod_reg) begin
          dir_next = DIR_DOWN;
          cnt_next = cnt_reg - 16'h0001;
          wrapEv = 1'b1;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end else begin
        if (cnt_reg == `TFE_ZERO16) begin
          dir_next = DIR_UP;
          cnt_next = cnt_reg + 16'h0001;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
    end
  end

  assign setEv[0] = wrapEv;

  // Per-channel input sync, edge detect and compare events
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gCh
      logic match;
      logic rise;
      logic fall;
      logic edgeHit;
      logic outNext;
      ch_mode_t mode;
      edge_sel_t esel;
      assign mode = ch_mode_t'(chCtrl_reg[g][`TFE_CHC_MODE_HI:`TFE_CHC_MODE_LO]);
      assign esel = edge_sel_t'(chCtrl_reg[g][`TFE_CHC_EDGE_HI:`TFE_CHC_EDGE_LO]);
      assign match = tick && (cnt_reg == chVal_reg[g]);
      assign rise = sync2_reg[g] && !prev_reg[g];
      assign fall = !sync2_reg[g] && prev_reg[g];
      // Edge select decode
      always_comb begin
        case (esel)
          EDGE_RISE: edgeHit = rise;
          EDGE_FALL: edgeHit = fall;
          EDGE_ANY: edgeHit = rise || fall;
          default: edgeHit = 1'b0;
        endcase
      end
      // Channel event: capture edge or counter match in any compare mode
      always_comb begin
        outNext = out_reg[g];
        case (mode)
          CH_CAPTURE: setEv[g+1] = edgeHit;
          CH_COMPARE: setEv[g+1] = match;
          CH_PWM: setEv[g+1] = match;
          default: setEv[g+1] = 1'b0;
        endcase
        if (mode == CH_COMPARE && match) begin
          outNext = !out_reg[g];
        end else if (mode == CH_PWM) begin
          if (match) begin
            outNext = 1'b0;
            if (center && dir_reg == DIR_DOWN) begin
              outNext = 1'b1;
            end
          end else if (wrapEv && !center) begin
            outNext = 1'b1;
          end
        end
      end
      // Sync stages, edge history and pin output
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
          out_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= chIn[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g] <= sync2_reg[g];
          out_reg[g] <= outNext;
        end
      end
      // Channel configuration written by software
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          chCtrl_reg[g] <= 4'h0;
          chVal_reg[g] <= `TFE_ZERO16;
        end else begin
          if (wr && addr == `TFE_ADDR_CH0CTRL + 4'(g)) begin
            chCtrl_reg[g] <= wdata[3:0];
          end
          if (wr && addr == `TFE_ADDR_CH0VAL + 4'(g)) begin
            chVal_reg[g] <= wdata;
          end
        end
      end
    end
    // Event flags, cleared by read-then-write-zero
    for (g = 0; g < NF; g++) begin : gFlag
      flag_clear_cell uFlag (
        .clk(clk),
        .resetn(resetn),
        .setEvent(setEv[g]),
        .readSeen(statRead),
        .writeZero(statWrite && !wdata[g]),
        .flag(flags[g])
      );
    end
  endgenerate

  // Register writes and read mux
  always_comb begin
    ctrl_next = ctrl_reg;
    mod_next = mod_reg;
    mask_next = mask_reg;
    rdata_next = `TFE_ZERO16;
    if (wr) begin
      case (addr)
        `TFE_ADDR_CTRL: ctrl_next = wdata;
        `TFE_ADDR_MOD: mod_next = wdata;
        `TFE_ADDR_MASK: mask_next = wdata[NF-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `TFE_ADDR_CTRL: rdata_next = ctrl_reg;
        `TFE_ADDR_MOD: rdata_next = mod_reg;
        `TFE_ADDR_CNT: rdata_next = cnt_reg;
        `TFE_ADDR_STATUS: rdata_next = 16'(flags);
        `TFE_ADDR_MASK: rdata_next = 16'(mask_reg);
        `TFE_ADDR_CH0CTRL: rdata_next = 16'(chCtrl_reg[0]);
        `TFE_ADDR_CH1CTRL: rdata_next = 16'(chCtrl_reg[1]);
        `TFE_ADDR_CH0VAL: rdata_next = chVal_reg[0];
        `TFE_ADDR_CH1VAL: rdata_next = chVal_reg[1];
        default: rdata_next = `TFE_ZERO16;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `TFE_CTRL_RESET;
      mod_reg <= `TFE_MOD_RESET;
      cnt_reg <= `TFE_CNT_RESET;
      mask_reg <= '0;
      pre_reg <= 4'h0;
      dir_reg <= DIR_UP;
      rdata_reg <= `TFE_ZERO16;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mod_reg <= mod_next;
      cnt_reg <= cnt_next;
      mask_reg <= mask_next;
      pre_reg <= pre_next;
      dir_reg <= dir_next;
      rdata_reg <= rdata_next;
      irq_reg <= |(flags & mask_reg);
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign chOut = out_reg;

  a_free_wrap: assert property (@(posedge clk)
    disable iff (!resetn)
    tick && !center && mod_reg == `TFE_ZERO16 && cnt_reg == `TFE_CNT_TOP
    |=> cnt_reg == `TFE_ZERO16 && flags[0])
    else $error("Free wrap missed");
  a_mod_wrap: assert property (@(posedge clk)
    disable iff (!resetn)
    tick && !center && mod_reg != `TFE_ZERO16 && cnt_reg == mod_reg
    |=> cnt_reg == `TFE_ZERO16 && flags[0])
    else $error("Modulus wrap missed");
  a_turn_down: assert property (@(posedge clk)
    disable iff (!resetn)
    tick && center && dir_reg == DIR_UP && cnt_reg == mod_reg
    && mod_reg != `TFE_ZERO16
    |=> dir_reg == DIR_DOWN && flags[0])
    else $error("Direction turn missed");
  a_center_mid: assert property (@(posedge clk)
    disable iff (!resetn)
    tick && center && dir_reg == DIR_DOWN && cnt_reg == `TFE_ZERO16
    |-> !wrapEv)
    else $error("Wrap at period middle");
  a_ch_match: assert property (@(posedge clk)
    disable iff (!resetn)
    tick && chCtrl_reg[0][1:0] != 2'b00 && chCtrl_reg[0][1:0] != 2'b11
    && cnt_reg == chVal_reg[0] |=> flags[1])
    else $error("Channel match flag missed");
  a_cap_off: assert property (@(posedge clk)
    disable iff (!resetn)
    chCtrl_reg[0] == 4'h0 |-> !setEv[1])
    else $error("Capture fired while off");
  a_cap_rise: assert property (@(posedge clk)
    disable iff (!resetn)
    chCtrl_reg[1] == 4'h4 && sync2_reg[1] && !prev_reg[1]
    |=> flags[2])
    else $error("Rising capture missed");
  a_irq_level: assert property (@(posedge clk)
    disable iff (!resetn)
    |(flags & mask_reg) |=> irq)
    else $error("Interrupt not raised");
  a_irq_quiet: assert property (@(posedge clk)
    disable iff (!resetn)
    !(|(flags & mask_reg)) |=> !irq)
    else $error("Interrupt raised with no enabled flag");
  a_flag_hold: assert property (@(posedge clk)
    disable iff (!resetn)
    flags[1] && !statWrite |=> flags[1])
    else $error("Flag dropped without clear");

  c_wrap: cover property (@(posedge clk) disable iff (!resetn) wrapEv);
  c_center_turn: cover property (@(posedge clk) disable iff (!resetn)
    center && $rose(dir_reg));
  c_capture: cover property (@(posedge clk) disable iff (!resetn)
    setEv[2] && chCtrl_reg[1][1:0] == 2'b00);
  c_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(irq_reg));
endmodule : timer_flag_event_logic

//--- verif/timer_flag_event_logic_test.sv
// Self-checking bench for the timer wrap and channel event flags
`timescale 1ns/10ps
`include "timer_flag_regs.svh"
module timer_flag_event_logic_test;
  import timer_flag_pkg::*;
  typedef struct {
    logic [15:0] e;
    logic [15:0] m;
  } note_t;
  localparam int LIMIT = 80000;
  logic clk, resetn, wr, rd, ch1Pin, chRand, rdLast, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [1:0] chOut;
  wire logic [1:0] chIn;
  note_t notes[$];
  note_t nt;
  int miscompares, totalChecks, cyc, m;

  assign chIn = {ch1Pin, chRand};

  timer_flag_event_logic #(.NCH(2)) u_dut (
    .clk(clk),
    .resetn(resetn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .chIn(chIn),
    .chOut(chOut),
    .irq(irq)
  );

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Read monitor: data stands in the cycle after the strobe
  always @(posedge clk) begin
    if (rdLast) begin
      nt = notes.pop_front();
      check("rdata", rdata & nt.m, nt.e);
    end
    rdLast <= rd;
  end

  // Unused channel pin toggles randomly, hang guard
  always @(posedge clk) begin
    chRand <= 1'($urandom());
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_exp(input logic [3:0] a, input logic [15:0] e,
                        input logic [15:0] mk);
    notes.push_back('{e: e, m: mk});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_exp

  task automatic do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    idle(12);
    resetn <= 1'b1;
  endtask : do_reset

  task automatic chk_irq(input logic e);
    // Interrupt is registered one cycle after flag or mask change
    @(posedge clk);
    @(negedge clk);
    check("irq", {15'h0000, irq}, {15'h0000, e});
  endtask : chk_irq

  // Main sequence
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rdLast = 1'b0;
    ch1Pin = 1'b0;
    chRand = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    cyc = 0;
    void'($urandom(32'h8a4c));
    do_reset();
    // Reset values and an unmapped index
    for (int a = 0; a < 5; a++) begin
      rd_exp(4'(a), 16'h0000, 16'hffff);
    end
    wr_reg(4'hf, 16'hffff);
    rd_exp(4'hf, 16'h0000, 16'hffff);
    // Modulus wrap, interrupt, clearing
    m = 16 + $urandom_range(15);
    wr_reg(`TFE_ADDR_MOD, 16'(m));
    wr_reg(`TFE_ADDR_MASK, 16'h0001);
    wr_reg(`TFE_ADDR_CTRL, 16'h0001);
    idle(m / 2);
    rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0001);
    idle(m);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0001);
    chk_irq(1'b1);
    wr_reg(`TFE_ADDR_CTRL, 16'h0000);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0001);
    wr_reg(`TFE_ADDR_STATUS, 16'h0000);
    rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0001);
    chk_irq(1'b0);
    // A wrap between read and write keeps the flag
    wr_reg(`TFE_ADDR_CTRL, 16'h0001);
    idle(m + 2);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0001);
    idle(m + 2);
    wr_reg(`TFE_ADDR_CTRL, 16'h0000);
    wr_reg(`TFE_ADDR_STATUS, 16'h0000);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0001);
    chk_irq(1'b1);
    wr_reg(`TFE_ADDR_MASK, 16'h0000);
    chk_irq(1'b0);
    // Free running count wraps after ffff
    do_reset();
    wr_reg(`TFE_ADDR_CTRL, 16'h0001);
    idle(65000);
    rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0001);
    idle(600);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0001);
    // Compare and edge PWM match events
    for (int md = 1; md < 3; md++) begin
      do_reset();
      wr_reg(`TFE_ADDR_CH0VAL, 16'h000c);
      wr_reg(`TFE_ADDR_CH0CTRL, 16'(md));
      wr_reg(`TFE_ADDR_MOD, 16'h0028);
      wr_reg(`TFE_ADDR_CTRL, 16'h0001);
      idle(2);
      rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0002);
      idle(15);
      rd_exp(`TFE_ADDR_STATUS, 16'h0002, 16'h0002);
      // Compare toggles high at the match; PWM drops there, rises at wrap
      @(negedge clk);
      check("chOut", 16'(chOut), 16'(md == 1));
      idle(22);
      @(negedge clk);
      check("chOut", 16'(chOut), 16'h0001);
    end
    // Capture edge selections on channel 1
    for (int es = 0; es < 4; es++) begin
      do_reset();
      wr_reg(`TFE_ADDR_CH1CTRL, 16'({es[1:0], 2'b00}));
      ch1Pin <= 1'b1;
      idle(6);
      rd_exp(`TFE_ADDR_STATUS, es[0] ? 16'h0004 : 16'h0000, 16'h0006);
      wr_reg(`TFE_ADDR_STATUS, 16'h0000);
      ch1Pin <= 1'b0;
      idle(6);
      rd_exp(`TFE_ADDR_STATUS, es[1] ? 16'h0004 : 16'h0000, 16'h0006);
    end
    // Center-aligned up/down period
    do_reset();
    wr_reg(`TFE_ADDR_MOD, 16'h001e);
    wr_reg(`TFE_ADDR_CH0VAL, 16'h000a);
    wr_reg(`TFE_ADDR_CH0CTRL, 16'(CH_PWM));
    wr_reg(`TFE_ADDR_CTRL, 16'h0003);
    idle(16);
    rd_exp(`TFE_ADDR_STATUS, 16'h0002, 16'h0003);
    wr_reg(`TFE_ADDR_STATUS, 16'h0000);
    idle(4);
    rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0003);
    idle(10);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0003);
    wr_reg(`TFE_ADDR_STATUS, 16'h0000);
    idle(12);
    rd_exp(`TFE_ADDR_STATUS, 16'h0002, 16'h0003);
    wr_reg(`TFE_ADDR_STATUS, 16'h0000);
    idle(8);
    rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0003);
    // Prescaled modulus count, channel 0 switched off
    do_reset();
    wr_reg(`TFE_ADDR_MOD, 16'h0004);
    wr_reg(`TFE_ADDR_CH0VAL, 16'h0002);
    wr_reg(`TFE_ADDR_CH0CTRL, 16'(CH_OFF));
    wr_reg(`TFE_ADDR_CTRL, 16'h0009);
    idle(17);
    rd_exp(`TFE_ADDR_STATUS, 16'h0000, 16'h0003);
    rd_exp(`TFE_ADDR_STATUS, 16'h0001, 16'h0003);
    idle(4);
    report_and_stop();
  end
endmodule : timer_flag_event_logic_test
